// >>> design/hpfo_pkg.sv
// Package of constants shared by the host port and frame offset logic
package hpfo_pkg;

  // ****************************************
  // Register addresses and fields
  // ****************************************
  localparam logic [7:0] ADDR_FRAME_OFFSET = 8'h0a;
  localparam logic [7:0] ADDR_CONN_HIGH    = 8'h0b;
  localparam logic [7:0] ADDR_CLOCK_MODE   = 8'h0c;
  localparam int         OFS_LSB           = 5;
  localparam int         OFS_MSB           = 7;
  localparam logic [2:0] OFS_RESET         = 3'h0;
  localparam logic [2:0] OFS_MAX           = 3'h4;
  localparam int         VC_BIT            = 6;
  localparam int         CLOCK_RATE_SELECT_BIT          = 0;

  // ****************************************
  // Timing
  // ****************************************
  localparam logic [3:0] CONTEND_CYCLES = 4'h3;

  typedef enum logic [1:0]
  {
    PORT_IDLE = 2'b00,
    PORT_WAIT = 2'b01,
    PORT_ACK  = 2'b10
  } port_state_e;

endpackage

// >>> design/offset_if.sv
// Interface carrying offset settings between port and frame aligner
`timescale 1ns/100ps
interface offset_if;
  logic [2:0] offset;
  logic       clock_rate_select;
  logic       frame_start;
  modport ctrl (output offset, output clock_rate_select, input frame_start);
  modport align (input offset, input clock_rate_select, output frame_start);
endinterface

// >>> design/frame_align.sv
// Frame aligner delaying the first-bit capture after the frame pulse
`timescale 1ns/100ps
module frame_align
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Serial timing
  input  wire logic bit_clk_en,
  input  wire logic frame_pulse,
  // Settings
  offset_if.align   ofs
);

  logic [3:0] remain;
  logic       half;
  logic       pending;
  logic       half_tick;

  // Half-rate enable when the interface clock runs at twice the bit rate
  always_ff @(posedge clk)
  begin
    if (rst)
      half <= 1'b0;
    else if (frame_pulse && bit_clk_en)
      half <= 1'b0;
    else if (bit_clk_en)
      half <= !half;
  end

  assign half_tick = bit_clk_en && (ofs.clock_rate_select || half);

  // Offset countdown from the frame pulse
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      remain  <= 4'h0;
      pending <= 1'b0;
      ofs.frame_start <= 1'b0;
    end
    else
    begin
      ofs.frame_start <= 1'b0;
      if (frame_pulse && bit_clk_en)
      begin
        if (ofs.offset == 3'h0)
          ofs.frame_start <= 1'b1;
        else
        begin
          remain  <= {1'b0, (ofs.offset > hpfo_pkg::OFS_MAX) ? hpfo_pkg::OFS_MAX : ofs.offset};
          pending <= 1'b1;
        end
      end
      else if (pending && half_tick)
      begin
        if (remain == 4'h1)
        begin
          pending         <= 1'b0;
          ofs.frame_start <= 1'b1;
        end
        remain <= remain - 4'h1;
      end
    end
  end

endmodule

// >>> design/host_port.sv
// Multiplexed host port with acknowledge handshake and frame offset control
`timescale 1ns/100ps
module host_port
(
  // Clock and reset
  input  wire logic       MCLK_I,
  input  wire logic       SRST_I,
  // Host bus
  input  wire logic       ALE_I,
  input  wire logic       CS_N_I,
  input  wire logic       RD_N_I,
  input  wire logic       WR_N_I,
  input  wire logic [7:0] AD_I,
  output logic      [7:0] AD_O,
  output logic            AD_OE_O,
  output logic            TRANSFER_ACK_N_O,
  output logic            TRANSFER_ACK_OE_O,
  // Serial timing
  input  wire logic       SERIAL_CLOCK_EN_I,
  input  wire logic       FRAME_PULSE_IN_I,
  input  wire logic       CONTENTION_I,
  // Frame and delay outputs
  output logic            FRAME_START_O,
  output logic            CONSTANT_DELAY_O
);

  offset_if ofs ();

  logic [7:0]              addr;
  logic                    ale_d;
  logic [2:0]              offset_sel;
  logic [7:0]              conn_high;
  logic                    clock_rate_select;
  logic [3:0]              wait_cnt;
  logic                    access;
  logic                    take;
  logic [2:0]              sel;
  hpfo_pkg::port_state_e   state;

  // ****************************************
  // Register decode
  // ****************************************
  function automatic logic [2:0] reg_sel
  (
    input logic [7:0] a
  );
    logic [2:0] hit;
    hit    = 3'h0;
    hit[0] = (a == hpfo_pkg::ADDR_FRAME_OFFSET);
    hit[1] = (a == hpfo_pkg::ADDR_CONN_HIGH);
    hit[2] = (a == hpfo_pkg::ADDR_CLOCK_MODE);
    return hit;
  endfunction

  // ****************************************
  // Access qualifiers
  // ****************************************
  assign access = !CS_N_I && (!RD_N_I || !WR_N_I);
  assign sel    = reg_sel(addr);
  assign take   = (state == hpfo_pkg::PORT_WAIT) && access && !CONTENTION_I && (wait_cnt == 4'h0);
  assign ofs.offset            = offset_sel;
  assign ofs.clock_rate_select = clock_rate_select;

  // ****************************************
  // Address latch
  // ****************************************
  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      ale_d <= 1'b0;
      addr  <= 8'h00;
    end
    else
    begin
      ale_d <= ALE_I;
      if (ale_d && !ALE_I)
        addr <= AD_I;
    end
  end

  // ****************************************
  // Access handshake
  // ****************************************
  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      state             <= hpfo_pkg::PORT_IDLE;
      wait_cnt          <= 4'h0;
      TRANSFER_ACK_N_O  <= 1'b1;
      TRANSFER_ACK_OE_O <= 1'b0;
    end
    else
    begin
      unique case (state)
        hpfo_pkg::PORT_IDLE:
        begin
          TRANSFER_ACK_N_O  <= 1'b1;
          TRANSFER_ACK_OE_O <= 1'b0;
          if (access)
          begin
            wait_cnt <= hpfo_pkg::CONTEND_CYCLES;
            state    <= hpfo_pkg::PORT_WAIT;
          end
        end
        hpfo_pkg::PORT_WAIT:
        begin
          if (!access)
            state <= hpfo_pkg::PORT_IDLE;
          else if (CONTENTION_I)
            wait_cnt <= hpfo_pkg::CONTEND_CYCLES;
          else if (take)
          begin
            TRANSFER_ACK_N_O  <= 1'b0;
            TRANSFER_ACK_OE_O <= 1'b1;
            state             <= hpfo_pkg::PORT_ACK;
          end
          else
            wait_cnt <= wait_cnt - 4'h1;
        end
        hpfo_pkg::PORT_ACK:
        begin
          if (!access)
          begin
            TRANSFER_ACK_N_O  <= 1'b1;
            TRANSFER_ACK_OE_O <= 1'b0;
            state             <= hpfo_pkg::PORT_IDLE;
          end
        end
        default:
        begin
          TRANSFER_ACK_N_O  <= 1'b1;
          TRANSFER_ACK_OE_O <= 1'b0;
          state             <= hpfo_pkg::PORT_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      offset_sel        <= hpfo_pkg::OFS_RESET;
      conn_high         <= 8'h00;
      clock_rate_select <= 1'b0;
    end
    else if (take && !WR_N_I)
    begin
      if (sel[0])
        offset_sel <= AD_I[hpfo_pkg::OFS_MSB:hpfo_pkg::OFS_LSB];
      if (sel[1])
        conn_high <= AD_I;
      if (sel[2])
        clock_rate_select <= AD_I[hpfo_pkg::CLOCK_RATE_SELECT_BIT];
    end
  end

  // Read data driven in the wait and acknowledge states while a read strobe is active
  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      AD_O    <= 8'h00;
      AD_OE_O <= 1'b0;
    end
    else
    begin
      AD_OE_O <= (state != hpfo_pkg::PORT_IDLE) && access && !RD_N_I;
      unique case (addr)
        hpfo_pkg::ADDR_FRAME_OFFSET: AD_O <= {offset_sel, 5'h00};
        hpfo_pkg::ADDR_CONN_HIGH:    AD_O <= conn_high;
        hpfo_pkg::ADDR_CLOCK_MODE:   AD_O <= {7'h00, clock_rate_select};
        default:                     AD_O <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Frame aligner and delay mode
  // ****************************************
  frame_align u_align
  (
    .clk         (MCLK_I),
    .rst         (SRST_I),
    .bit_clk_en  (SERIAL_CLOCK_EN_I),
    .frame_pulse (FRAME_PULSE_IN_I),
    .ofs         (ofs.align)
  );

  always_ff @(posedge MCLK_I)
  begin
    if (SRST_I)
    begin
      FRAME_START_O    <= 1'b0;
      CONSTANT_DELAY_O <= 1'b0;
    end
    else
    begin
      FRAME_START_O    <= ofs.frame_start;
      CONSTANT_DELAY_O <= conn_high[hpfo_pkg::VC_BIT];
    end
  end

endmodule

// >>> verification/cpu_glue.sv
// Model of the CPU and its latch glue on the multiplexed host bus
`timescale 1ns/100ps
module cpu_glue
(
  // Bus from device
  input  wire logic       clk,
  input  wire logic       ack_n,
  input  wire logic [7:0] din,
  // Bus to device
  output logic            ale,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [7:0] ad,
  output logic      [7:0] rdata
);
  initial
  begin
    {ale, cs_n, rd_n, wr_n} = 4'h7;
    ad = 8'h00;
    rdata = 8'h00;
  end

  task access(input logic we, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 ale = 1'b1;
    ad = a;
    @(posedge clk);
    #1 ale = 1'b0;
    @(posedge clk);
    #1 ad = we ? d : ~a;
    cs_n = 1'b0;
    wr_n = !we;
    rd_n = we;
    do @(posedge clk); while (ack_n !== 1'b0);
    if (!we) rdata = din;
    #1 {cs_n, rd_n, wr_n} = 3'h7;
    ad = ~ad;
    do @(posedge clk); while (ack_n !== 1'b1);
  endtask
endmodule

// >>> verification/hp_checker.sv
// Assertion checker for the host port
`timescale 1ns/100ps
module hp_checker
(
  // Watched ports
  input wire logic       MCLK_I,
  input wire logic       SRST_I,
  input wire logic       ALE_I,
  input wire logic       CS_N_I,
  input wire logic       RD_N_I,
  input wire logic       WR_N_I,
  input wire logic [7:0] AD_I,
  input wire logic [7:0] AD_O,
  input wire logic       AD_OE_O,
  input wire logic       TRANSFER_ACK_N_O,
  input wire logic       TRANSFER_ACK_OE_O,
  input wire logic       SERIAL_CLOCK_EN_I,
  input wire logic       FRAME_PULSE_IN_I,
  input wire logic       CONTENTION_I,
  input wire logic       FRAME_START_O,
  input wire logic       CONSTANT_DELAY_O
);
  wire strobe = !CS_N_I && !(RD_N_I && WR_N_I);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);

  chk_ack_oe_pair: assert property (TRANSFER_ACK_OE_O == !TRANSFER_ACK_N_O)
    else $error("ack enable wrong");
  chk_ack_min_wait: assert property ($fell(TRANSFER_ACK_N_O) |-> $past(strobe, 1) && $past(strobe, 5))
    else $error("ack too early");
  chk_ack_release: assert property (!TRANSFER_ACK_N_O && !strobe |=> TRANSFER_ACK_N_O)
    else $error("ack not released");
  chk_ack_cause: assert property (!TRANSFER_ACK_N_O |-> $past(strobe))
    else $error("ack without strobe");
  chk_contend_hold: assert property (CONTENTION_I && TRANSFER_ACK_N_O |=> TRANSFER_ACK_N_O)
    else $error("ack during contention");
  chk_read_drive: assert property (AD_OE_O |-> $past(!RD_N_I && !CS_N_I))
    else $error("bus driven outside read");
  chk_read_oe_on: assert property (!TRANSFER_ACK_N_O && !RD_N_I && !CS_N_I |-> AD_OE_O)
    else $error("read data not driven");
  chk_frame_single: assert property (FRAME_START_O |=> !FRAME_START_O)
    else $error("frame start too long");
  chk_reset_state: assert property (disable iff (1'b0) SRST_I |=> TRANSFER_ACK_N_O && !AD_OE_O && !FRAME_START_O)
    else $error("bad reset state");

  cover property ($fell(TRANSFER_ACK_N_O) && !RD_N_I);
  cover property ($fell(TRANSFER_ACK_N_O) && !WR_N_I);
  cover property (CONTENTION_I && strobe);
  cover property (FRAME_START_O);
endmodule

bind host_port hp_checker i_chk (.*);

// >>> verification/tb_top.sv
// Self-checking bench for the host port and frame offset
`timescale 1ns/100ps
module tb_top;
  logic        mclk = 0, srst = 1, fpi = 0, cont = 0;
  logic        ale, cs_n, rd_n, wr_n, ack_n, ack_oe, ad_oe, fst, cdl, sce;
  logic [7:0]  ad_i, ad_o, v, x;
  logic [1:0]  ecnt = 2'h0;
  logic [31:0] seed = 32'h14, r;
  int          mismatches = 0, cmp_count = 0, cyc = 0, d0, n;

  assign sce = (ecnt == 2'h0);
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) ecnt <= ecnt + 2'h1;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      mismatches++;
      report_and_stop();
    end
  end

  host_port i_dut (.MCLK_I(mclk), .SRST_I(srst), .ALE_I(ale), .CS_N_I(cs_n), .RD_N_I(rd_n), .WR_N_I(wr_n),
    .AD_I(ad_i), .AD_O(ad_o), .AD_OE_O(ad_oe), .TRANSFER_ACK_N_O(ack_n), .TRANSFER_ACK_OE_O(ack_oe),
    .SERIAL_CLOCK_EN_I(sce), .FRAME_PULSE_IN_I(fpi), .CONTENTION_I(cont), .FRAME_START_O(fst),
    .CONSTANT_DELAY_O(cdl));
  cpu_glue i_glue (.clk(mclk), .ack_n(!ack_oe), .din(ad_o), .ale(ale), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .ad(ad_i), .rdata(v));

  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function logic [7:0] exp_ofs(input logic [7:0] w);
    return {w[7:5], 5'h00};
  endfunction

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task rd2(input logic [7:0] a);
    i_glue.access(1'b0, a, 8'h00);
    i_glue.access(1'b0, a, 8'h00);
  endtask

  task frame(output int k);
    do @(posedge mclk); while (ecnt != 2'h3);
    #1 fpi = 1'b1;
    @(posedge mclk);
    #1 fpi = 1'b0;
    k = 1;
    while (fst !== 1'b1 && k < 100)
    begin
      @(posedge mclk);
      #1 k++;
    end
  endtask

  task report_and_stop();
    $display("compares=%0d mismatches=%0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge mclk);
    #1 srst = 1'b0;
    chk({5'h0, ack_n, ad_oe, cdl}, 8'h04);
    rd2(hpfo_pkg::ADDR_FRAME_OFFSET);
    chk(v, 8'h00);
    for (int c = 0; c < 5; c++)
    begin
      r = rnd();
      x = {c[2:0], r[4:0]};
      i_glue.access(1'b1, hpfo_pkg::ADDR_FRAME_OFFSET, x);
      rd2(hpfo_pkg::ADDR_FRAME_OFFSET);
      chk(v, exp_ofs(x));
    end
    $display("offset register test done");
    for (int k = 0; k < 2; k++)
    begin
      r = rnd() ^ {25'h0, k[0], 6'h0};
      fork
        i_glue.access(1'b1, hpfo_pkg::ADDR_CONN_HIGH, r[7:0]);
        begin
          repeat (3) @(posedge mclk);
          #1 cont = 1'b1;
          repeat (6) @(posedge mclk);
          #1 cont = 1'b0;
        end
      join
      chk({7'h0, cdl}, {7'h0, r[6]});
      rd2(hpfo_pkg::ADDR_CONN_HIGH);
      chk({7'h0, v[6]}, {7'h0, r[6]});
    end
    i_glue.access(1'b1, 8'h3f, 8'ha5);
    rd2(8'h3f);
    chk(v, 8'h00);
    $display("delay mode and contention test done");
    for (int m = 1; m < 3; m++)
    begin
      i_glue.access(1'b1, hpfo_pkg::ADDR_CLOCK_MODE, {7'h0, m == 1});
      rd2(hpfo_pkg::ADDR_CLOCK_MODE);
      chk(v, {7'h0, m == 1});
      for (int c = 0; c < 5; c++)
      begin
        i_glue.access(1'b1, hpfo_pkg::ADDR_FRAME_OFFSET, {c[2:0], 5'h00});
        frame(n);
        if (c == 0) d0 = n;
        if (c == 0) chk(8'(n), 8'h02);
        else chk(8'(n - d0), 8'(c * 4 * m));
      end
    end
    $display("frame offset test done");
    report_and_stop();
  end
endmodule
